/* File: verilog/trm_reset_map.v */
// transceiver reset and power-down map with reconfiguration busy flag
//
// Summary of operation
// RULE1: lock-mode status output high in lock-to-data, low in lock-to-reference.
// RULE2: busy low for first clock after power up, high from the second.
// RULE3: busy stays high during offset cancellation; falling marks its end.
// RULE4: busy also high for every analog or channel reconfiguration operation.
// RULE5: PLL reset clears only the PLLs, no datapath sub-block.
// RULE6: transmit digital reset clears tx PCS sub-blocks, never the transmitter buffer.
// RULE7: receive digital reset clears word aligner through BIST verifiers.
// RULE8: receive analog reset clears only the receiver CDR.
// RULE9: block power-down covers all channel parts except PLLs; buffers/deserializer only by it.
// RULE10: all reset and power-down inputs act asynchronously, with no clock.
// RULE11: the controller holds each channel reset at least two parallel clocks.
// RULE12: a block with no channels present stays powered down.
//
// all reset fan-out is combinational so the pins act with the clock stopped;
// only the lock flag, the busy sequencer and the control register use pclk.
// limitation: a reconfiguration request that arrives while busy is dropped,
// software has to poll the busy status bit before writing.
// power-down also forces every tx/rx pcs reset and the cdr reset.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "trm_consts.vh"

module trm_reset_map #(
  parameter NUM_CH = 4,
  parameter OC_CYCLES = `TRM_OC_CYCLES,
  parameter ANALOG_CYCLES = `TRM_ANALOG_CYCLES,
  parameter CHANNEL_CYCLES = `TRM_CHANNEL_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire pll_reset_in,
  input wire tx_digital_reset_in,
  input wire rx_analog_reset_in,
  input wire rx_digital_reset_in,
  input wire block_powerdown_in,
  input wire [NUM_CH-1:0] channel_present,
  input wire lock_to_ref_req,
  input wire lock_to_data_req,
  input wire cdr_freq_ok,
  output wire pll_reset,
  output wire [`TRM_TX_W-1:0] tx_pcs_reset,
  output wire tx_buffer_powerdown,
  output wire rx_buffer_powerdown,
  output wire rx_cdr_reset,
  output wire rx_deser_powerdown,
  output wire [`TRM_RX_W-1:0] rx_pcs_reset,
  output wire block_powered_down,
  output wire cdr_lock_data,
  output wire busy
);

  localparam ST_FIRST = 2'h0;
  localparam ST_OFFSET = 2'h1;
  localparam ST_IDLE = 2'h2;
  localparam ST_RECONF = 2'h3;

  reg [4:0] ctrl_q;
  reg [1:0] state_q;
  reg [15:0] count_q;
  reg ltd_q;
  reg busy_q;

  // ==========================================
  // address decode, shared by write strobe, error flag and read mux
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // ==========================================
  // APB decode
  wire wr_en = psel & penable & pwrite & clk_en;
  wire hit_ctrl = addr_hit(paddr, `TRM_OFF_CTRL);
  wire hit_status = addr_hit(paddr, `TRM_OFF_STATUS);
  wire hit_reconf = addr_hit(paddr, `TRM_OFF_RECONF);
  wire hit_any = hit_ctrl | hit_status | hit_reconf;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================
  // asynchronous reset and power-down fan-out
  // purely combinational so a reset pin acts with no clock edge running
  wire pd_all = block_powerdown_in | ctrl_q[`TRM_CTRL_PD] | ~(|channel_present); // see RULE12
  // software copies of the reset pins, ored in below
  wire ctrl_pll = ctrl_q[`TRM_CTRL_PLL];
  wire ctrl_txd = ctrl_q[`TRM_CTRL_TXD];
  wire ctrl_rxa = ctrl_q[`TRM_CTRL_RXA];
  wire ctrl_rxd = ctrl_q[`TRM_CTRL_RXD];
  wire txd = tx_digital_reset_in | ctrl_txd;
  wire rxd = rx_digital_reset_in | ctrl_rxd;
  wire rxa = rx_analog_reset_in | ctrl_rxa;

  assign block_powered_down = pd_all; // see RULE10
  assign pll_reset = pll_reset_in | ctrl_pll; // see RULE5

  genvar gi;
  generate
    for (gi = 0; gi < `TRM_TX_W; gi = gi + 1) begin : g_tx_rst
      // transmitter buffer is not in this vector, only power-down reaches it
      assign tx_pcs_reset[gi] = txd | pd_all; // see RULE6
    end
  endgenerate

  assign tx_buffer_powerdown = pd_all; // see RULE9
  assign rx_buffer_powerdown = pd_all; // see RULE9
  assign rx_deser_powerdown = pd_all; // see RULE9
  assign rx_cdr_reset = rxa | pd_all; // see RULE8

  generate
    for (gi = 0; gi < `TRM_RX_W; gi = gi + 1) begin : g_rx_rst
      // cdr and deserializer stay outside, so rx digital reset keeps the link locked
      assign rx_pcs_reset[gi] = rxd | pd_all; // see RULE7
    end
  endgenerate

  // ==========================================
  // CDR lock mode: manual lock-to-data wins, then lock-to-reference, else automatic
  wire ltd_d = ~rx_cdr_reset & (lock_to_data_req | (~lock_to_ref_req & cdr_freq_ok));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ltd_q <= 1'b0;
    end else if (clk_en) begin
      ltd_q <= ltd_d; // see RULE1
    end
  end

  assign cdr_lock_data = ltd_q;

  // ==========================================
  // control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TRM_CTRL_RESET;
    end else if (wr_en && hit_ctrl) begin
      ctrl_q <= pwdata[4:0];
    end
  end

  // ==========================================
  // busy sequencer: offset cancellation after power up, then reconfiguration runs
  // a reconfiguration request while busy is dropped, software polls busy first
  wire [1:0] rc_mode = pwdata[`TRM_RC_MODE_MSB:`TRM_RC_MODE_LSB];
  // counter is loaded with n-1; busy drops on the edge after it reaches zero
  wire [15:0] oc_load = OC_CYCLES[15:0] - 16'h0001;
  wire [15:0] rc_load = (rc_mode == `TRM_RC_ANALOG) ? (ANALOG_CYCLES[15:0] - 16'h0001) :
                        (CHANNEL_CYCLES[15:0] - 16'h0001);
  wire rc_start = wr_en & hit_reconf & (state_q == ST_IDLE) &
                  ((rc_mode == `TRM_RC_ANALOG) | (rc_mode == `TRM_RC_CHANNEL));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_FIRST;
      count_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_FIRST: begin
          state_q <= ST_OFFSET; // see RULE2
          count_q <= oc_load;
          busy_q <= 1'b1;
        end
        ST_OFFSET, ST_RECONF: begin
          if (count_q == 16'h0000) begin
            state_q <= ST_IDLE; // see RULE3
            busy_q <= 1'b0;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        ST_IDLE: begin
          if (rc_start) begin
            state_q <= ST_RECONF; // see RULE4
            busy_q <= 1'b1;
            count_q <= rc_load;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign busy = busy_q;

  // ==========================================
  // read mux, data taken by master at access phase
  always @* begin
    prdata = 32'h00000000;
    if (hit_ctrl) begin
      prdata[4:0] = ctrl_q;
    end else if (hit_status) begin
      prdata[`TRM_ST_LTD] = ltd_q;
      prdata[`TRM_ST_BUSY] = busy_q;
      prdata[`TRM_ST_PD] = pd_all;
    end
  end

endmodule

/* File: verilog/trm_consts.vh */
// constants for the transceiver reset and power-down map
`ifndef TRM_CONSTS_VH
`define TRM_CONSTS_VH
// ==========================================
// register byte offsets
`define TRM_OFF_CTRL 12'h000
`define TRM_OFF_STATUS 12'h004
`define TRM_OFF_RECONF 12'h008
// ==========================================
// control register fields
`define TRM_CTRL_PLL 0
`define TRM_CTRL_TXD 1
`define TRM_CTRL_RXA 2
`define TRM_CTRL_RXD 3
`define TRM_CTRL_PD 4
`define TRM_CTRL_RESET 5'h00
// ==========================================
// status register fields
`define TRM_ST_LTD 0
`define TRM_ST_BUSY 1
`define TRM_ST_PD 2
// ==========================================
// reconfiguration register fields and modes
`define TRM_RC_MODE_LSB 0
`define TRM_RC_MODE_MSB 1
`define TRM_RC_ANALOG 2'h1
`define TRM_RC_CHANNEL 2'h2
// ==========================================
// transmit digital sub-block bits
`define TRM_TX_PCFIFO 0
`define TRM_TX_BYTESER 1
`define TRM_TX_ENC 2
`define TRM_TX_SER 3
`define TRM_TX_XAUI 4
`define TRM_TX_W 5
// ==========================================
// receive digital sub-block bits
`define TRM_RX_ALIGN 0
`define TRM_RX_DESKEW 1
`define TRM_RX_RATECOMP 2
`define TRM_RX_DEC 3
`define TRM_RX_BYTEDES 4
`define TRM_RX_ORDER 5
`define TRM_RX_PCFIFO 6
`define TRM_RX_XAUI 7
`define TRM_RX_BIST 8
`define TRM_RX_W 9
// ==========================================
// busy timing defaults, in reconfiguration clock cycles
`define TRM_OC_CYCLES 64
`define TRM_ANALOG_CYCLES 16
`define TRM_CHANNEL_CYCLES 32
`endif

/* File: tb/trm_properties.sv */
// checker for the reset map ports
`timescale 1ns/1ps
`include "trm_consts.vh"
module trm_props #(parameter NUM_CH = 4) (
  input wire pclk, input wire presetn, input wire clk_en, input wire pll_reset_in,
  input wire tx_digital_reset_in, input wire rx_analog_reset_in, input wire rx_digital_reset_in,
  input wire block_powerdown_in, input wire [NUM_CH-1:0] channel_present, input wire lock_to_ref_req,
  input wire lock_to_data_req, input wire cdr_freq_ok, input wire pll_reset, input wire [`TRM_TX_W-1:0] tx_pcs_reset,
  input wire tx_buffer_powerdown, input wire rx_buffer_powerdown, input wire rx_cdr_reset,
  input wire rx_deser_powerdown, input wire [`TRM_RX_W-1:0] rx_pcs_reset, input wire block_powered_down,
  input wire cdr_lock_data, input wire busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_lock_mode: assert property ($past(presetn) && $past(clk_en) |-> cdr_lock_data == $past(!rx_cdr_reset &&
    (lock_to_data_req || !lock_to_ref_req && cdr_freq_ok))) else $error("lock flag wrong");
  a_busy_start: assert property ($rose(presetn) && clk_en |-> !busy ##1 busy) else $error("busy start");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:300] !busy) else $error("busy stuck");
  a_pll_map: assert property (pll_reset_in |-> pll_reset) else $error("pll reset lost");
  a_tx_map: assert property (tx_digital_reset_in |-> &tx_pcs_reset) else $error("tx pcs reset lost");
  a_rx_map: assert property (rx_digital_reset_in |-> &rx_pcs_reset) else $error("rx pcs reset lost");
  a_cdr_map: assert property (rx_analog_reset_in |-> rx_cdr_reset) else $error("cdr reset lost");
  a_pd_only: assert property ({tx_buffer_powerdown, rx_buffer_powerdown, rx_deser_powerdown}
    == {3{block_powered_down}}) else $error("buffer powerdown wrong");
  a_no_chan: assert property (channel_present == 0 |-> block_powered_down) else $error("empty block up");
  cover property ($fell(busy));
  cover property (block_powered_down && !block_powerdown_in);
  cover property (!clk_en && rx_analog_reset_in);
endmodule
bind trm_reset_map trm_props #(.NUM_CH(NUM_CH)) u_props (.*);

/* File: tb/trm_fabric.sv */
// fabric reset controller model
`timescale 1ns/1ps
module trm_fabric (
  input wire pclk,
  input wire presetn,
  input wire [4:0] req,
  output reg [4:0] rst_q
);
  reg [4:0] old_q;
  // a fresh reset is kept one more clock, so no pulse is shorter than two
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 5'h1F;
      old_q <= 5'h00;
    end else begin
      rst_q <= req | (rst_q & ~old_q);
      old_q <= rst_q;
    end
  end
endmodule

/* File: tb/trm_reset_map_tb.sv */
// bench for the reset map
`timescale 1ns/1ps
`include "trm_consts.vh"
module trm_reset_map_tb;
  reg pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, er, elk = 0, ce = 0;
  reg lock_to_ref_req = 0, lock_to_data_req = 0, cdr_freq_ok = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, lfsr = 32'h68F5D4F5;
  reg [4:0] req = 0, ctrl = 5'h01;
  reg [3:0] channel_present = 4'hF;
  reg [19:0] e;
  wire pll_reset_in, tx_digital_reset_in, rx_analog_reset_in, rx_digital_reset_in, block_powerdown_in;
  wire pready, pslverr, pll_reset, tx_buffer_powerdown, rx_buffer_powerdown, rx_cdr_reset, rx_deser_powerdown;
  wire block_powered_down, cdr_lock_data, busy;
  wire [31:0] prdata;
  wire [4:0] tx_pcs_reset, rst;
  wire [8:0] rx_pcs_reset;
  integer errors = 0, n_checks = 0, i, n;
  assign {block_powerdown_in, rx_digital_reset_in, rx_analog_reset_in, tx_digital_reset_in, pll_reset_in} = rst;
  always #10 pclk = ~pclk;
  trm_fabric fab (.pclk(pclk), .presetn(presetn), .req(req), .rst_q(rst));
  trm_reset_map #(.OC_CYCLES(4), .ANALOG_CYCLES(3), .CHANNEL_CYCLES(5)) dut (.*);
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [19:0] expv(input [4:0] r, input [3:0] c);
    reg pd;
    begin
      pd = r[4] | ~|c;
      expv = {r[0], {5{r[1] | pd}}, pd, pd, r[2] | pd, pd, {9{r[3] | pd}}, pd};
    end
  endfunction
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      for (n = 0; n < 50 && pready !== 1'b1; n = n + 1) @(posedge pclk);
      if (n == 50) chk(0, 1);
      if (n == 50) close_out;
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task bwait(input integer want);
    begin
      @(negedge pclk);
      for (n = 0; n < 300 && busy === 1'b1; n = n + 1) @(negedge pclk);
      chk(n, want);
    end
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(busy, 0);
    bwait(4);
    for (i = 1; i < 3; i = i + 1) begin
      apb(1, `TRM_OFF_RECONF, i);
      bwait(i * 2 + 1);
    end
    apb(1, `TRM_OFF_CTRL, ctrl);
    apb(0, `TRM_OFF_CTRL, 0);
    chk(rd, ctrl);
    apb(0, 12'hFF0, 0);
    chk(er, 1);
    for (i = 0; i < 400; i = i + 1) begin
      @(posedge pclk);
      lfsr = nxt(lfsr);
      req <= lfsr[4:0] & lfsr[9:5];
      channel_present <= lfsr[13:10];
      {lock_to_ref_req, lock_to_data_req, cdr_freq_ok} <= lfsr[16:14];
      clk_en <= i < 200 || i > 230;
      @(negedge pclk);
      e = expv(rst | ctrl, channel_present);
      chk({pll_reset, tx_pcs_reset, tx_buffer_powerdown, rx_buffer_powerdown, rx_cdr_reset, rx_deser_powerdown,
        rx_pcs_reset, block_powered_down}, e);
      if (ce) chk(cdr_lock_data, elk);
      elk = !e[11] && (lock_to_data_req || !lock_to_ref_req && cdr_freq_ok);
      ce = clk_en;
    end
    close_out;
  end
endmodule
